// File: verilog/emac_dma_pkg.sv
// Purpose: Shared constants for the MAC DMA status and queue pointer block
// Assumes: Byte offsets on an 8-bit register address, 32-bit data
// Notes:   Queue pointers are kept as word addresses (bits 31..2)
package emac_dma_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS  = 8'h00;
  localparam logic [7:0] TSTAT_OFS = 8'h14;
  localparam logic [7:0] RQP_OFS   = 8'h18;
  localparam logic [7:0] TQP_OFS   = 8'h1c;
  localparam logic [7:0] RSTAT_OFS = 8'h20;
  localparam logic [7:0] ISTAT_OFS = 8'h24;

  // Control register fields
  localparam int CTRL_RE = 2;
  localparam int CTRL_TE = 3;
  localparam logic [1:0] CTRL_RST = 2'h0;

  // Transmit status fields
  localparam int TS_USED   = 0;
  localparam int TS_COL    = 1;
  localparam int TS_RETRY  = 2;
  localparam int TS_ACTIVE = 3;
  localparam int TS_BEX    = 4;
  localparam int TS_COMP   = 5;
  localparam int TS_UND    = 6;
  localparam int TS_W      = 7;

  // Receive status fields
  localparam int RS_BNA = 0;
  localparam int RS_REC = 1;
  localparam int RS_OVR = 2;
  localparam int RS_W   = 3;

  // Interrupt status fields
  localparam int IS_MFD   = 0;
  localparam int IS_RX_COMPLETE_IRQ = 1;
  localparam int IS_RXUSE = 2;
  localparam int IS_TXUSE = 3;
  localparam int IS_TX_UNDERRUN_IRQ  = 4;
  localparam int IS_W     = 5;

  // Queue pointer reset value, descriptor step and wrap count
  localparam logic [29:0] PTR_RST         = 30'h0;
  localparam logic [29:0] DESC_STEP       = 30'h2;
  localparam int          DESC_WRAP_COUNT = 1024;

endpackage : emac_dma_pkg

// File: verilog/sticky_flags.sv
// Purpose: Bank of sticky status flags
// Assumes: Set and clear are one-cycle requests
// Notes:   A set in the cycle of a clear leaves the flag set
`timescale 1ns/1ps
module sticky_flags #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  // Requests
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  // Flag state
  output logic      [W-1:0] flags_q
);

  if (W < 1) begin : g_bad_width
    $error("sticky_flags needs at least one flag");
  end

  // Clear first, then set, so no event is lost
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      flags_q <= '0;
    end else begin
      flags_q <= (flags_q & ~clr) | set;
    end
  end

endmodule : sticky_flags

// File: verilog/queue_pointer.sv
// Purpose: Descriptor queue pointer with list start, frame head and wrap
// Assumes: Advance, mark and rewind come from the DMA as one-cycle pulses
// Notes:   Addresses are word addresses; one descriptor is two words
`timescale 1ns/1ps
module queue_pointer
  import emac_dma_pkg::*;
#(
  parameter int WRAP = DESC_WRAP_COUNT
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // Software load of the list start
  input  wire logic        load,
  input  wire logic [29:0] load_addr,
  // DMA progress
  input  wire logic        advance,
  input  wire logic        wrap_bit,
  input  wire logic        mark_frame,
  input  wire logic        rewind_frame,
  input  wire logic        rewind_list,
  // Pointer values
  output logic      [29:0] cur_q,
  output logic      [29:0] head_q
);

  localparam int CW = $clog2(WRAP);

  if (WRAP < 2 || (WRAP & (WRAP - 1)) != 0) begin : g_bad_wrap
    $error("queue_pointer wrap count must be a power of two");
  end

  logic [29:0]   start_q;    // List start as written
  logic [CW-1:0] cnt_q;      // Buffers used since list start
  logic [CW-1:0] head_cnt_q; // Count at the frame head
  logic          at_wrap;    // This advance returns to start

  assign at_wrap = wrap_bit || (cnt_q == CW'(WRAP - 1));

  // List start register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      start_q <= PTR_RST;
    end else if (load) begin
      start_q <= load_addr;
    end
  end

  // Current descriptor pointer and buffer count
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cur_q <= PTR_RST;
      cnt_q <= '0;
    end else if (load) begin
      cur_q <= load_addr;
      cnt_q <= '0;
    end else if (rewind_list) begin
      cur_q <= start_q;
      cnt_q <= '0;
    end else if (rewind_frame) begin
      cur_q <= head_q;
      cnt_q <= head_cnt_q;
    end else if (advance) begin
      // Wrap on the wrap bit or after the full count of buffers
      if (at_wrap) begin
        cur_q <= start_q;
        cnt_q <= '0;
      end else begin
        cur_q <= cur_q + DESC_STEP;
        cnt_q <= cnt_q + CW'(1);
      end
    end
  end

  // First descriptor of the current frame
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      head_q     <= PTR_RST;
      head_cnt_q <= '0;
    end else if (load) begin
      head_q     <= load_addr;
      head_cnt_q <= '0;
    end else if (rewind_list) begin
      head_q     <= start_q;
      head_cnt_q <= '0;
    end else if (mark_frame) begin
      head_q     <= cur_q;
      head_cnt_q <= cnt_q;
    end
  end

endmodule : queue_pointer

// File: verilog/emac_dma_status.sv
// Purpose: Status flags and descriptor queue pointers of a MAC DMA path
// Assumes: DMA and transmitter events are one-cycle pulses on sys_clk
// Notes:   Read data appear one cycle after the read strobe
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

// Functional notes
// - Status flags clear by written one; interrupt flags by read
// - Transmit used descriptor sets status bit 0
// - Collision sets transmit status bit 1
// - Transmit status bit 3 shows live activity
// - Mid-frame buffer exhaustion: bad FCS, tx_er, bit4
// - Finished frame sets transmit status bit 5
// - Fetch failure forces bad CRC, sets bit 6
// - Receive pointer loads, advances, wraps at 1024
// - Receive pointer read shows current descriptor
// - Transmit pointer wraps; reads frame's first buffer
// - Transmit pointer writes only while idle
// - Owned receive descriptor sets bit 0, retries
// - Stored frames set receive status bit 1
// - Receive store failure sets bit 2, recovers
// - Management done sets interrupt bit 0
// - Stored frame sets interrupt bit 1
// - Used descriptors set interrupt bits 2, 3
// - Underrun causes or pointer write set bit 4
// - Transmit disable rewinds transmit pointer to start
// - Receive disable stops, clears FIFO, keeps pointer
module emac_dma_status
  import emac_dma_pkg::*;
#(
  parameter int WRAP = DESC_WRAP_COUNT
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Transmit events
  input  wire logic        tx_used_bit_seen,
  input  wire logic        tx_collision,
  input  wire logic        retry_limit_hit,
  input  wire logic        transmit_active,
  input  wire logic        buffers_exhausted_midframe,
  input  wire logic        tx_frame_done,
  input  wire logic        tx_late_grant,
  input  wire logic        tx_bus_error,
  input  wire logic        tx_used_midframe,
  input  wire logic        tx_desc_advance,
  input  wire logic        tx_desc_wrap,
  // Receive events
  input  wire logic        rx_used_bit_seen,
  input  wire logic        rx_frame_start,
  input  wire logic        rx_frame_stored,
  input  wire logic        rx_late_grant,
  input  wire logic        rx_bus_error,
  input  wire logic        rx_desc_advance,
  input  wire logic        rx_desc_wrap,
  // Management events
  input  wire logic        mgmt_done,
  // Descriptor addresses to the DMA
  output logic      [31:0] rx_desc_addr,
  output logic      [31:0] tx_desc_addr,
  // Control to the MAC
  output logic             transmit_enable_bit,
  output logic             receive_enable_bit,
  output logic             tx_force_bad_crc,
  output logic             tx_er,
  output logic             rx_fifo_clear,
  output logic             rx_refetch_pending
);

  // Address match, shared by the write and read decoders
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a[7:2] == ofs[7:2]);
  endfunction : hit

  // Decoded strobes
  logic wr_ctrl;   // Control register write
  logic wr_tstat;  // Transmit status write
  logic wr_rqp;    // Receive queue pointer write
  logic wr_tqp;    // Transmit queue pointer write, accepted
  logic wr_rstat;  // Receive status write
  logic rd_istat;  // Interrupt status read

  // Control state
  logic [1:0] ctrl_q;      // Enable bits {te, re}
  logic       te_fall;     // Transmit enable cleared now
  logic       re_fall;     // Receive enable cleared now

  // Flag banks
  logic [TS_W-1:0] ts_set;
  logic [TS_W-1:0] ts_clr;
  logic [TS_W-1:0] ts_q;
  logic [RS_W-1:0] rs_set;
  logic [RS_W-1:0] rs_clr;
  logic [RS_W-1:0] rs_q;
  logic [IS_W-1:0] is_set;
  logic [IS_W-1:0] is_clr;
  logic [IS_W-1:0] is_q;

  // Derived events
  logic tx_fetch_fail;  // Underrun cause seen this cycle
  logic rx_store_fail;  // Overrun cause seen this cycle

  // Queue pointer values
  logic [29:0] rq_cur;
  logic [29:0] rq_head;
  logic [29:0] tq_cur;
  logic [29:0] tq_head;

  // Read data next value
  logic [31:0] rdata_d;

  // Write decode, if/else-if chain on the address
  always_comb begin
    wr_ctrl  = 1'b0;
    wr_tstat = 1'b0;
    wr_rqp   = 1'b0;
    wr_tqp   = 1'b0;
    wr_rstat = 1'b0;
    if (!reg_wr) begin
      wr_ctrl = 1'b0;
    end else if (hit(reg_addr, CTRL_OFS)) begin
      wr_ctrl = 1'b1;
    end else if (hit(reg_addr, TSTAT_OFS)) begin
      wr_tstat = 1'b1;
    end else if (hit(reg_addr, RQP_OFS)) begin
      wr_rqp = 1'b1;
    end else if (hit(reg_addr, TQP_OFS)) begin
      // Ignored while the transmitter runs
      wr_tqp = !transmit_active;
    end else if (hit(reg_addr, RSTAT_OFS)) begin
      wr_rstat = 1'b1;
    end
  end

  // Interrupt status is cleared by any read of it
  assign rd_istat = reg_rd && hit(reg_addr, ISTAT_OFS);

  // Falling edges of the enables, seen in the write cycle
  assign te_fall = wr_ctrl && ctrl_q[1] && !reg_wdata[CTRL_TE];
  assign re_fall = wr_ctrl && ctrl_q[0] && !reg_wdata[CTRL_RE];

  // Control register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= {reg_wdata[CTRL_TE], reg_wdata[CTRL_RE]};
    end
  end

  assign transmit_enable_bit = ctrl_q[1];
  assign receive_enable_bit  = ctrl_q[0];

  // Fetch and store failure causes
  assign tx_fetch_fail = tx_late_grant || tx_bus_error || tx_used_midframe;
  assign rx_store_fail = rx_late_grant || rx_bus_error;

  // Transmit status sources
  always_comb begin
    ts_set            = '0;
    ts_set[TS_USED]   = tx_used_bit_seen;
    ts_set[TS_COL]    = tx_collision;
    ts_set[TS_RETRY]  = retry_limit_hit;
    ts_set[TS_BEX]    = buffers_exhausted_midframe;
    ts_set[TS_COMP]   = tx_frame_done;
    ts_set[TS_UND]    = tx_fetch_fail;
    // Write one clears; the live bit is not a flag
    ts_clr            = wr_tstat ? reg_wdata[TS_W-1:0] : '0;
    ts_clr[TS_ACTIVE] = 1'b0;
  end

  // Receive status sources
  always_comb begin
    rs_set         = '0;
    rs_set[RS_BNA] = rx_used_bit_seen;
    rs_set[RS_REC] = rx_frame_stored;
    rs_set[RS_OVR] = rx_store_fail;
    rs_clr         = wr_rstat ? reg_wdata[RS_W-1:0] : '0;
  end

  // Interrupt status sources
  always_comb begin
    is_set           = '0;
    is_set[IS_MFD]   = mgmt_done;
    is_set[IS_RX_COMPLETE_IRQ] = rx_frame_stored;
    is_set[IS_RXUSE] = rx_used_bit_seen;
    is_set[IS_TXUSE] = tx_used_bit_seen;
    is_set[IS_TX_UNDERRUN_IRQ]  = tx_fetch_fail || wr_tqp;
    is_clr           = rd_istat ? '1 : '0;
  end

  // Transmit status flags
  sticky_flags #(
    .W       (TS_W)
  ) u_tstat (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .set     (ts_set),
    .clr     (ts_clr),
    .flags_q (ts_q)
  );

  // Receive status flags
  sticky_flags #(
    .W       (RS_W)
  ) u_rstat (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .set     (rs_set),
    .clr     (rs_clr),
    .flags_q (rs_q)
  );

  // Interrupt status flags
  sticky_flags #(
    .W       (IS_W)
  ) u_istat (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .set     (is_set),
    .clr     (is_clr),
    .flags_q (is_q)
  );

  // Receive queue pointer; overrun rewinds to the frame's first buffer
  queue_pointer #(
    .WRAP         (WRAP)
  ) u_rxq (
    .sys_clk      (sys_clk),
    .rstn         (rstn),
    .load         (wr_rqp),
    .load_addr    (reg_wdata[31:2]),
    .advance      (rx_desc_advance),
    .wrap_bit     (rx_desc_wrap),
    .mark_frame   (rx_frame_start),
    .rewind_frame (rx_store_fail),
    .rewind_list  (1'b0),
    .cur_q        (rq_cur),
    .head_q       (rq_head)
  );

  // Transmit queue pointer; disable returns it to the list start
  queue_pointer #(
    .WRAP         (WRAP)
  ) u_txq (
    .sys_clk      (sys_clk),
    .rstn         (rstn),
    .load         (wr_tqp),
    .load_addr    (reg_wdata[31:2]),
    .advance      (tx_desc_advance),
    .wrap_bit     (tx_desc_wrap),
    .mark_frame   (tx_frame_done),
    .rewind_frame (1'b0),
    .rewind_list  (te_fall),
    .cur_q        (tq_cur),
    .head_q       (tq_head)
  );

  // Descriptor addresses for the DMA engine
  assign rx_desc_addr = {rq_cur, 2'b00};
  assign tx_desc_addr = {tq_cur, 2'b00};

  // Error marking on the transmit side
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tx_force_bad_crc <= 1'b0;
      tx_er            <= 1'b0;
    end else begin
      tx_force_bad_crc <= tx_fetch_fail || buffers_exhausted_midframe;
      tx_er            <= buffers_exhausted_midframe;
    end
  end

  // Receive FIFO flush when reception is disabled
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rx_fifo_clear <= 1'b0;
    end else begin
      rx_fifo_clear <= re_fall;
    end
  end

  // Descriptor re-read request until a valid one is found
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rx_refetch_pending <= 1'b0;
    end else if (rx_used_bit_seen) begin
      rx_refetch_pending <= 1'b1;
    end else if (rx_desc_advance) begin
      rx_refetch_pending <= 1'b0;
    end
  end

  // Read multiplexer, if/else-if chain; unmapped reads give zero
  always_comb begin
    rdata_d = 32'h0;
    if (hit(reg_addr, CTRL_OFS)) begin
      rdata_d[CTRL_TE] = ctrl_q[1];
      rdata_d[CTRL_RE] = ctrl_q[0];
    end else if (hit(reg_addr, TSTAT_OFS)) begin
      rdata_d[TS_W-1:0]  = ts_q;
      rdata_d[TS_ACTIVE] = transmit_active;
    end else if (hit(reg_addr, RQP_OFS)) begin
      rdata_d = {rq_cur, 2'b00};
    end else if (hit(reg_addr, TQP_OFS)) begin
      rdata_d = {tq_head, 2'b00};
    end else if (hit(reg_addr, RSTAT_OFS)) begin
      rdata_d[RS_W-1:0] = rs_q;
    end else if (hit(reg_addr, ISTAT_OFS)) begin
      rdata_d[IS_W-1:0] = is_q;
    end
  end

  // Registered read data, held between reads
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end
  end

endmodule : emac_dma_status

// File: test/emac_dma_status_props.sv
// Purpose: Port checks for the MAC DMA status block
// Assumes: One clock domain, async active-low reset
// Notes:   Attached by bind from the bench top
`timescale 1ns/1ps
module emac_dma_status_props
  import emac_dma_pkg::*;
#(
  parameter int WRAP = DESC_WRAP_COUNT
) (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rstn,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // Events
  input wire logic        buffers_exhausted_midframe,
  input wire logic        tx_late_grant,
  input wire logic        tx_bus_error,
  input wire logic        tx_used_midframe,
  input wire logic        tx_used_bit_seen,
  input wire logic        rx_used_bit_seen,
  input wire logic        rx_frame_stored,
  input wire logic        mgmt_done,
  input wire logic        rx_desc_advance,
  input wire logic        rx_desc_wrap,
  input wire logic        rx_late_grant,
  input wire logic        rx_bus_error,
  // Outputs
  input wire logic [31:0] rx_desc_addr,
  input wire logic        receive_enable_bit,
  input wire logic        rx_fifo_clear,
  input wire logic        tx_er,
  input wire logic        tx_force_bad_crc
);
  logic fail_ev; // Any cause of a bad transmit CRC
  logic is_ev;   // Any event feeding the interrupt flags
  logic is_rd;   // Read of the interrupt flags
  logic rq_wr;   // Load of the receive list start
  assign fail_ev = tx_late_grant | tx_bus_error | tx_used_midframe | buffers_exhausted_midframe;
  assign is_ev = fail_ev | tx_used_bit_seen | rx_used_bit_seen | rx_frame_stored | mgmt_done;
  assign is_rd = reg_rd & (reg_addr == ISTAT_OFS);
  assign rq_wr = reg_wr & (reg_addr == RQP_OFS);

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  property p_txer;
    tx_er == $past(buffers_exhausted_midframe);
  endproperty
  a_txer: assert property (p_txer) else $error("tx_er off exhaustion");
  property p_crc;
    fail_ev |=> tx_force_bad_crc;
  endproperty
  a_crc: assert property (p_crc) else $error("no bad crc");
  property p_ptrlo;
    reg_rd && (reg_addr == RQP_OFS || reg_addr == TQP_OFS) |=> reg_rdata[1:0] == 2'h0;
  endproperty
  a_ptrlo: assert property (p_ptrlo) else $error("pointer low bits set");
  property p_load;
    rq_wr |=> rx_desc_addr[31:2] == $past(reg_wdata[31:2]);
  endproperty
  a_load: assert property (p_load) else $error("receive pointer not loaded");
  property p_adv;
    rq_wr ##2 (rx_desc_advance && !rx_desc_wrap && !reg_wr && !rx_late_grant && !rx_bus_error)
      |=> rx_desc_addr == $past(rx_desc_addr) + 32'h8;
  endproperty
  a_adv: assert property (p_adv) else $error("receive pointer step wrong");
  property p_rxoff;
    reg_wr && reg_addr == CTRL_OFS && !reg_wdata[CTRL_RE] && receive_enable_bit
      |=> rx_fifo_clear && !receive_enable_bit;
  endproperty
  a_rxoff: assert property (p_rxoff) else $error("receive disable wrong");
  property p_isclr;
    is_rd && !is_ev ##1 is_rd |=> reg_rdata[IS_W-1:0] == '0;
  endproperty
  a_isclr: assert property (p_isclr) else $error("flags kept after read");
  property p_setwin;
    mgmt_done && is_rd ##1 is_rd |=> reg_rdata[IS_MFD];
  endproperty
  a_setwin: assert property (p_setwin) else $error("event lost in clear");
  c_setwin: cover property (mgmt_done && is_rd);
  c_rxoff: cover property (rx_fifo_clear);
  c_txer: cover property (tx_er);
endmodule : emac_dma_status_props

// File: test/dma_event_model.sv
// Purpose: Stand-in for the DMA and MAC event sources
// Assumes: req is a pulse vector from the bench
// Notes:   slow adds one cycle of latency
`timescale 1ns/1ps
module dma_event_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // Requests
  input  wire logic [17:0] req,
  input  wire logic        slow,
  // Event pulses
  output logic      [17:0] ev
);
  logic [17:0] s1_q; // First delay stage
  logic [17:0] s2_q; // Second delay stage
  // Events leave one or two cycles after the request
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= req;
      s2_q <= s1_q;
    end
  end
  assign ev = slow ? s2_q : s1_q;
endmodule : dma_event_model

// File: test/tb.sv
// Purpose: Self-checking bench for the MAC DMA status block
// Assumes: Event model drives every event input except transmit_active, which the bench drives
// Notes:   Wrap count shortened to 8
`timescale 1ns/1ps
module tb;
  import emac_dma_pkg::*;
  localparam int WR = 8; // Short wrap count
  localparam logic [7:0] OFS [7] = '{CTRL_OFS, TSTAT_OFS, RQP_OFS, TQP_OFS, RSTAT_OFS,
                                     ISTAT_OFS, 8'h40};
  // Event index, interrupt, receive and transmit flags
  localparam logic [31:0] TBL [13] = '{32'h00080001, 32'h01000002, 32'h02000004,
    32'h03000010, 32'h04000020, 32'h05100040, 32'h06100040, 32'h07100040,
    32'h0a040100, 32'h0c020200, 32'h0d000400, 32'h0e000400, 32'h11010000};
  logic        sys_clk;
  logic        rstn;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        transmit_active;
  logic [17:0] req;            // Event requests
  logic        slow;           // Model latency
  logic [17:0] ev;             // Event pulses
  logic [31:0] rx_desc_addr;
  logic [31:0] tx_desc_addr;
  logic [5:0]  ctl_out;        // Control outputs
  logic        rd_seen = 1'b0; // Read taken at last edge
  logic [31:0] exp_q [$];      // Expected read data
  logic [31:0] rb;             // Receive list start
  logic [31:0] tbs;            // Transmit list start
  int          err_total = 0;
  int          samples_checked = 0;

  dma_event_model i_dma_event_model (.sys_clk(sys_clk), .rstn(rstn), .req(req), .slow(slow),
    .ev(ev));
  emac_dma_status #(.WRAP(WR)) i_emac_dma_status (.sys_clk(sys_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tx_used_bit_seen(ev[0]), .tx_collision(ev[1]),
    .retry_limit_hit(ev[2]), .transmit_active(transmit_active),
    .buffers_exhausted_midframe(ev[3]), .tx_frame_done(ev[4]), .tx_late_grant(ev[5]),
    .tx_bus_error(ev[6]), .tx_used_midframe(ev[7]), .tx_desc_advance(ev[8]),
    .tx_desc_wrap(ev[9]), .rx_used_bit_seen(ev[10]), .rx_frame_start(ev[11]),
    .rx_frame_stored(ev[12]), .rx_late_grant(ev[13]), .rx_bus_error(ev[14]),
    .rx_desc_advance(ev[15]), .rx_desc_wrap(ev[16]), .mgmt_done(ev[17]),
    .rx_desc_addr(rx_desc_addr), .tx_desc_addr(tx_desc_addr),
    .transmit_enable_bit(ctl_out[0]), .receive_enable_bit(ctl_out[1]),
    .tx_force_bad_crc(ctl_out[2]), .tx_er(ctl_out[3]), .rx_fifo_clear(ctl_out[4]),
    .rx_refetch_pending(ctl_out[5]));

  always #5 sys_clk = ~sys_clk;

  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic print_verdict();
    if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  task automatic wr(logic [7:0] a, logic [31:0] d);
    reg_wr    <= 1'b1;
    reg_rd    <= 1'b0;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
  endtask : wr

  // Queue the expected data, then issue the read
  task automatic rd(logic [7:0] a, logic [31:0] e);
    exp_q.push_back(e);
    reg_rd   <= 1'b1;
    reg_wr   <= 1'b0;
    reg_addr <= a;
    @(posedge sys_clk);
  endtask : rd

  task automatic idle(int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask : idle

  // Hold an event request for n cycles
  task automatic pulse(logic [17:0] v, int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    req    <= v;
    repeat (n) @(posedge sys_clk);
    req <= 18'h0;
  endtask : pulse

  // Read data stand in the cycle after the strobe
  always @(posedge sys_clk) rd_seen <= reg_rd;
  always @(negedge sys_clk) begin
    if (rd_seen === 1'b1) begin
      chk("reg_rdata", reg_rdata, (exp_q.size() != 0) ? exp_q.pop_front() : 32'hx);
    end
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    print_verdict();
  end

  initial begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    transmit_active = 1'b0;
    req = 18'h0;
    slow = 1'b0;
    void'($urandom(35397));
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    // Reset values, unmapped place, writes that cannot set
    foreach (OFS[i]) rd(OFS[i], 32'h0);
    wr(TSTAT_OFS, 32'hff);
    wr(RSTAT_OFS, 32'hff);
    wr(ISTAT_OFS, 32'h1f);
    rd(TSTAT_OFS, 32'h0);
    rd(ISTAT_OFS, 32'h0);
    // Each event sets its flags; W1C and read clear them
    foreach (TBL[i]) begin
      slow <= i[0];
      pulse(18'h1 << TBL[i][31:24], 1);
      idle(3);
      rd(TSTAT_OFS, {24'h0, TBL[i][7:0]});
      rd(RSTAT_OFS, {24'h0, TBL[i][15:8]});
      rd(ISTAT_OFS, {24'h0, TBL[i][23:16]});
      rd(ISTAT_OFS, 32'h0);
      wr(TSTAT_OFS, {24'h0, TBL[i][7:0]});
      wr(RSTAT_OFS, {24'h0, TBL[i][15:8]});
      rd(TSTAT_OFS, 32'h0);
      rd(RSTAT_OFS, 32'h0);
    end
    slow <= 1'b0;
    // Refetch request stands after the unavailable-buffer event
    idle(1);
    @(negedge sys_clk);
    chk("ctl_out", {26'h0, ctl_out}, 32'h20);
    @(posedge sys_clk);
    // Events that meet a clear survive it
    pulse(18'h1 << 17, 1);
    rd(ISTAT_OFS, 32'h0);
    rd(ISTAT_OFS, 32'h1);
    pulse(18'h1 << 4, 1);
    wr(TSTAT_OFS, 32'h20);
    rd(TSTAT_OFS, 32'h20);
    wr(TSTAT_OFS, 32'h20);
    // Receive list: load, step, disable, wrap bit, wrap count, recovery
    rb = $urandom & 32'hffff_fffb;
    wr(RQP_OFS, rb);
    rb = {rb[31:2], 2'h0};
    pulse(18'h1 << 15, 3);
    idle(2);
    rd(RQP_OFS, rb + 32'h18);
    wr(CTRL_OFS, 32'h4);
    wr(CTRL_OFS, 32'h0);
    rd(RQP_OFS, rb + 32'h18);
    pulse(18'h3 << 15, 1);
    idle(2);
    rd(RQP_OFS, rb);
    pulse(18'h1 << 15, WR);
    idle(2);
    rd(RQP_OFS, rb);
    pulse(18'h1 << 11, 1);
    idle(1);
    pulse(18'h1 << 15, 2);
    idle(1);
    pulse(18'h1 << 13, 1);
    idle(2);
    rd(RQP_OFS, rb);
    rd(RSTAT_OFS, 32'h4);
    wr(RSTAT_OFS, 32'h4);
    // Transmit list: head, refused write while busy, disable rewind
    tbs = $urandom & 32'hffff_fff8;
    wr(TQP_OFS, tbs);
    rd(ISTAT_OFS, 32'h10);
    rd(TQP_OFS, tbs);
    wr(CTRL_OFS, 32'h8);
    pulse(18'h1 << 8, 2);
    idle(1);
    pulse(18'h1 << 4, 1);
    idle(2);
    // Transmit enabled, refetch request dropped by the receive advances
    @(negedge sys_clk);
    chk("ctl_out", {26'h0, ctl_out}, 32'h1);
    @(posedge sys_clk);
    rd(TQP_OFS, tbs + 32'h10);
    transmit_active <= 1'b1;
    wr(TQP_OFS, ~tbs);
    rd(TQP_OFS, tbs + 32'h10);
    rd(ISTAT_OFS, 32'h0);
    rd(TSTAT_OFS, 32'h28);
    transmit_active <= 1'b0;
    wr(CTRL_OFS, 32'h0);
    rd(TQP_OFS, tbs);
    idle(2);
    @(negedge sys_clk);
    chk("tx_desc_addr", tx_desc_addr, tbs);
    chk("rx_desc_addr", rx_desc_addr, rb);
    chk("ctl_out", {26'h0, ctl_out}, 32'h0);
    @(posedge sys_clk);
    chk("pending reads", 32'(exp_q.size()), 32'h0);
    print_verdict();
  end
endmodule : tb

bind emac_dma_status emac_dma_status_props #(.WRAP(WRAP)) i_emac_dma_status_props (
  .sys_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .buffers_exhausted_midframe, .tx_late_grant, .tx_bus_error, .tx_used_midframe,
  .tx_used_bit_seen, .rx_used_bit_seen, .rx_frame_stored, .mgmt_done, .rx_desc_advance,
  .rx_desc_wrap, .rx_late_grant, .rx_bus_error, .rx_desc_addr, .receive_enable_bit,
  .rx_fifo_clear, .tx_er, .tx_force_bad_crc);
